/* File: logic/mmvd_params.svh */
// constants for the memory map and vector decoder
// assumes a 16-bit byte-addressed cpu bus on one clock
// Function
// [R1] the decoder covers a 64 Kbyte space addressed by 16 bits.
// [R2] addresses 0000h to 007Fh select peripheral registers, also by short direct addressing.
// [R3] ram at 0080h to 00FFh is reachable by short direct addressing and by full address.
// [R4] 0100h to 01FFh serves as banked general registers and stays ordinary ram.
// [R5] the register region holds 8, 16 or 32 banks ending at 013Fh, 017Fh or 01FFh.
// [R6] reset does not clear or initialise ram contents.
// [R7] FFC0h to FFFFh is the vector table, each entry a 16-bit handler address.
// [R8] vector call n takes its target from FFC0h plus 2n, upper byte at the even address.
// [R9] irq line zero uses FFFAh, each higher line the next lower entry, down to FFE4h.
// [R10] the reset vector is read upper byte at FFFEh and lower byte at FFFFh.
// [R11] the mode-data byte sits at FFFDh and FFFCh is unused and holds FFh.
// [R12] 16-bit memory accesses put the upper byte at the address and the lower next.
// [R13] a 16-bit operand is taken upper byte first right after the opcode.
// [R14] a 16-bit stack push puts the upper byte at the lower stack address.
// [R15] reset loads the program counter with the mode-data address FFFDh.
// [R16] addresses outside io, implemented ram and rom go to the external area.
`ifndef MMVD_PARAMS_SVH
`define MMVD_PARAMS_SVH
`define MMVD_IO_LO 16'h0000
`define MMVD_IO_HI 16'h007F
`define MMVD_DIR_LO 16'h0080
`define MMVD_DIR_HI 16'h00FF
`define MMVD_GPR_LO 16'h0100
`define MMVD_GPR_HI8 16'h013F
`define MMVD_GPR_HI16 16'h017F
`define MMVD_GPR_HI32 16'h01FF
`define MMVD_BANK_BYTES 16'h0008
`define MMVD_VEC_LO 16'hFFC0
`define MMVD_VEC_HI 16'hFFFF
`define MMVD_VECTOR_CALL_INSTR_BASE 16'hFFC0
`define MMVD_IRQ_LINE_ZERO_VEC 16'hFFFA
`define MMVD_IRQ_LAST 4'hB
`define MMVD_MODE_UNUSED 16'hFFFC
`define MMVD_MODE_DATA 16'hFFFD
`define MMVD_RESET_VEC 16'hFFFE
`define MMVD_UNUSED_FILL 8'hFF
`define MMVD_RAM_TOP 16'h047F
`define MMVD_ROM_BASE 16'hE000
`endif

/* File: logic/mmvd_pkg.sv */
// types for the memory map and vector decoder
// assumes the params header sits beside it
package mmvd_pkg;
  typedef enum logic [1:0] {
    MMVD_SZ_BYTE,
    MMVD_SZ_WORD
  } mmvd_size_type;

  typedef enum logic [2:0] {
    MMVD_VK_NONE,
    MMVD_VK_VECTOR_CALL_INSTR,
    MMVD_VK_IRQ,
    MMVD_VK_MODE,
    MMVD_VK_RESET
  } mmvd_vkind_type;

  typedef struct packed {
    logic io;
    logic ram;
    logic direct;
    logic gpr;
    logic vec;
    logic rom;
    logic ext;
    logic unused_fill;
  } mmvd_sel_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } mmvd_beat_type;
endpackage

/* File: logic/mmvd_region_decode.sv */
// combinational region decoder for one 16-bit byte address
// assumes ram and rom bounds are set by the instantiating top
`timescale 1ns/1ps
`include "mmvd_params.svh"
module mmvd_region_decode #(
  parameter logic [15:0] RAM_TOP = `MMVD_RAM_TOP,
  parameter logic [15:0] ROM_BASE = `MMVD_ROM_BASE,
  parameter logic [15:0] GPR_TOP = `MMVD_GPR_HI32
) (
  input wire logic [15:0] i_addr,
  output mmvd_pkg::mmvd_sel_type o_sel
);
  import mmvd_pkg::*;

  // ==========================================
  // region compare
  always_comb begin
    o_sel = '0;
    o_sel.io = (i_addr <= `MMVD_IO_HI); // [R2]
    o_sel.direct = (i_addr >= `MMVD_DIR_LO) && (i_addr <= `MMVD_DIR_HI); // [R3]
    o_sel.ram = (i_addr > `MMVD_IO_HI) && (i_addr <= RAM_TOP);
    // gpr window stays plain ram as well
    o_sel.gpr = (i_addr >= `MMVD_GPR_LO) && (i_addr <= GPR_TOP) && o_sel.ram; // [R4] [R5]
    o_sel.rom = (i_addr >= ROM_BASE);
    o_sel.vec = (i_addr >= `MMVD_VEC_LO); // [R7]
    o_sel.unused_fill = (i_addr == `MMVD_MODE_UNUSED); // [R11]
    o_sel.ext = !(o_sel.io || o_sel.ram || o_sel.rom); // [R16]
  end
endmodule

/* File: logic/mmvd_decoder.sv */
// memory map, vector address and byte-order sequencer for an 8-bit cpu
// assumes the cpu core on the same clock; ram content itself lives elsewhere
`timescale 1ns/1ps
`include "mmvd_params.svh"
module mmvd_decoder #(
  parameter int GPR_BANKS = 32,
  parameter logic [15:0] RAM_TOP = `MMVD_RAM_TOP,
  parameter logic [15:0] ROM_BASE = `MMVD_ROM_BASE
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input mmvd_pkg::mmvd_beat_type i_req,
  input mmvd_pkg::mmvd_size_type i_size,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0] i_rdata_byte,
  input wire logic i_direct_mode,
  input wire logic [7:0] i_direct_off,
  input wire logic i_gpr_mode,
  input wire logic [4:0] i_bank,
  input wire logic [2:0] i_gpr_idx,
  input wire logic i_vector_call_instr,
  input wire logic [2:0] i_vcall_idx,
  input wire logic i_irq_take,
  input wire logic [3:0] i_irq_num,
  input wire logic i_reset_fetch,
  input wire logic i_mode_fetch,
  output logic o_busy,
  output logic [15:0] o_bus_addr,
  output logic o_bus_valid,
  output logic o_bus_write,
  output logic [7:0] o_bus_wdata,
  output mmvd_pkg::mmvd_sel_type o_sel,
  output logic [15:0] o_rdata,
  output logic o_rdone,
  output logic [15:0] o_pc_reset,
  output logic o_bad_vec
);
  import mmvd_pkg::*;

  // ==========================================
  // helpers
  // size of the gpr window depends on the variant bank count
  localparam logic [15:0] GPR_TOP = (GPR_BANKS == 8) ? `MMVD_GPR_HI8 :
    (GPR_BANKS == 16) ? `MMVD_GPR_HI16 : `MMVD_GPR_HI32; // [R5]

  function automatic logic [15:0] vec_vector_call_instr(input logic [2:0] n);
    vec_vector_call_instr = `MMVD_VECTOR_CALL_INSTR_BASE + {12'h000, n, 1'b0}; // [R8]
  endfunction

  function automatic logic [15:0] vec_irq(input logic [3:0] n);
    vec_irq = `MMVD_IRQ_LINE_ZERO_VEC - {11'h000, n, 1'b0}; // [R9]
  endfunction

  // ==========================================
  // state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HI,
    ST_LO
  } mmvd_st_type;

  mmvd_st_type st_q, st_d;
  logic [15:0] base_q, base_d;
  logic [15:0] wd_q, wd_d;
  logic wr_q, wr_d;
  logic word_q, word_d;
  logic [7:0] hi_q, hi_d;
  logic [15:0] rdata_q, rdata_d;
  logic rdone_q, rdone_d;
  logic [15:0] addr_q, addr_d;
  logic valid_q, valid_d;
  logic bwr_q, bwr_d;
  logic [7:0] bwd_q, bwd_d;
  logic bad_q, bad_d;
  logic busy_q, busy_d;
  logic [15:0] pc_q, pc_d;
  mmvd_sel_type sel_w;
  mmvd_sel_type sel_q;

  // decode of the next bus address, registered in step with it
  mmvd_region_decode #(
    .RAM_TOP(RAM_TOP),
    .ROM_BASE(ROM_BASE),
    .GPR_TOP(GPR_TOP)
  ) u_region (
    .i_addr(addr_d),
    .o_sel(sel_w)
  );

  // ==========================================
  // request sequencing
  always_comb begin
    logic [15:0] a;
    logic go;
    a = i_req.addr; // [R1]
    go = 1'b0;
    st_d = st_q;
    base_d = base_q;
    wd_d = wd_q;
    wr_d = wr_q;
    word_d = word_q;
    hi_d = hi_q;
    rdata_d = rdata_q;
    rdone_d = 1'b0;
    addr_d = addr_q;
    valid_d = 1'b0;
    bwr_d = 1'b0;
    bwd_d = bwd_q;
    bad_d = 1'b0;
    pc_d = `MMVD_MODE_DATA; // [R15]
    case (st_q)
      ST_IDLE: begin
        // priority: reset vector, mode data, irq, vector call, plain access
        if (i_reset_fetch) begin
          a = `MMVD_RESET_VEC; // [R10]
          go = 1'b1;
          wr_d = 1'b0;
          word_d = 1'b1;
        end else if (i_mode_fetch) begin
          a = `MMVD_MODE_DATA; // [R11]
          go = 1'b1;
          wr_d = 1'b0;
          word_d = 1'b0;
        end else if (i_irq_take) begin
          bad_d = (i_irq_num > `MMVD_IRQ_LAST);
          a = vec_irq(i_irq_num); // [R9]
          go = !bad_d;
          wr_d = 1'b0;
          word_d = 1'b1;
        end else if (i_vector_call_instr) begin
          a = vec_vector_call_instr(i_vcall_idx); // [R8]
          go = 1'b1;
          wr_d = 1'b0;
          word_d = 1'b1;
        end else if (i_req.valid) begin
          if (i_direct_mode) begin
            a = {8'h00, i_direct_off}; // [R2] [R3]
          end else if (i_gpr_mode) begin
            a = `MMVD_GPR_LO + {8'h00, i_bank, i_gpr_idx}; // [R4]
          end
          go = 1'b1;
          wr_d = i_req.write;
          word_d = (i_size == MMVD_SZ_WORD);
        end
        if (go) begin
          base_d = a;
          wd_d = i_wdata;
          addr_d = a;
          valid_d = 1'b1;
          bwr_d = wr_d;
          // upper byte goes to the lower address first
          bwd_d = word_d ? i_wdata[15:8] : i_wdata[7:0]; // [R12] [R14]
          st_d = ST_HI;
        end
      end
      ST_HI: begin
        if (word_q) begin
          hi_d = i_rdata_byte; // [R13]
          addr_d = base_q + 16'h0001; // [R12]
          valid_d = 1'b1;
          bwr_d = wr_q;
          bwd_d = wd_q[7:0];
          st_d = ST_LO;
        end else begin
          rdata_d = {8'h00, i_rdata_byte};
          rdone_d = !wr_q;
          st_d = ST_IDLE;
        end
      end
      ST_LO: begin
        rdata_d = {hi_q, i_rdata_byte}; // [R12] [R13]
        rdone_d = !wr_q;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // busy is registered so the cpu sees it from a flop, not from state decode
    busy_d = (st_d != ST_IDLE);
  end

  // ram contents are never touched here, so reset clears no storage
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin // [R6]
    if (!i_resetn) begin
      st_q <= ST_IDLE;
      base_q <= 16'h0000;
      wd_q <= 16'h0000;
      wr_q <= 1'b0;
      word_q <= 1'b0;
      hi_q <= 8'h00;
      rdata_q <= 16'h0000;
      rdone_q <= 1'b0;
      addr_q <= `MMVD_MODE_DATA; // [R15]
      valid_q <= 1'b0;
      bwr_q <= 1'b0;
      bwd_q <= 8'h00;
      bad_q <= 1'b0;
      sel_q <= '0;
      busy_q <= 1'b0;
      pc_q <= `MMVD_MODE_DATA; // [R15]
    end else begin
      st_q <= st_d;
      base_q <= base_d;
      wd_q <= wd_d;
      wr_q <= wr_d;
      word_q <= word_d;
      hi_q <= hi_d;
      rdata_q <= rdata_d;
      rdone_q <= rdone_d;
      addr_q <= addr_d;
      valid_q <= valid_d;
      bwr_q <= bwr_d;
      bwd_q <= bwd_d;
      bad_q <= bad_d;
      sel_q <= sel_w;
      busy_q <= busy_d;
      pc_q <= pc_d;
    end
  end

  // ==========================================
  // outputs
  assign o_busy = busy_q;
  assign o_bus_addr = addr_q;
  assign o_bus_valid = valid_q;
  assign o_bus_write = bwr_q;
  assign o_bus_wdata = bwd_q;
  assign o_sel = sel_q;
  assign o_rdata = rdata_q;
  assign o_rdone = rdone_q;
  assign o_pc_reset = pc_q; // [R15]
  assign o_bad_vec = bad_q;
endmodule

/* File: verif/mmvd_decoder_properties.sv */
// assertions on the ports of the memory map and vector decoder
// assumes it is bound onto mmvd_decoder
`timescale 1ns/1ps
module mmvd_checker
  import mmvd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input mmvd_pkg::mmvd_beat_type i_req,
  input mmvd_pkg::mmvd_size_type i_size,
  input wire logic i_vector_call_instr,
  input wire logic [2:0] i_vcall_idx,
  input wire logic i_irq_take,
  input wire logic [3:0] i_irq_num,
  input wire logic i_reset_fetch,
  input wire logic i_mode_fetch,
  input wire logic o_busy,
  input wire logic [15:0] o_bus_addr,
  input wire logic o_bus_valid,
  input mmvd_pkg::mmvd_sel_type o_sel,
  input wire logic o_rdone,
  input wire logic [15:0] o_pc_reset,
  input wire logic o_bad_vec
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // ==========================================
  // takes, with the documented priority
  logic hi, irq_go, vc_go, rq_go;
  assign hi = i_reset_fetch || i_mode_fetch;
  assign irq_go = !o_busy && !hi && i_irq_take;
  assign vc_go = !o_busy && !hi && !i_irq_take && i_vector_call_instr;
  assign rq_go = !o_busy && !hi && !i_irq_take && !i_vector_call_instr && i_req.valid;
  a_pc_const: assert property (o_pc_reset == 16'hFFFD) else $error("pc reset wrong");
  a_reset_vec: assert property (!o_busy && i_reset_fetch |=> o_bus_addr == 16'hFFFE
    ##1 o_bus_valid && o_bus_addr == 16'hFFFF) else $error("reset vector beats wrong");
  a_mode_byte: assert property (!o_busy && i_mode_fetch && !i_reset_fetch
    |=> o_bus_valid && o_bus_addr == 16'hFFFD) else $error("mode byte address wrong");
  a_irq_addr: assert property (irq_go && i_irq_num <= 4'hB |=> o_bus_valid
    && o_bus_addr == 16'hFFFA - {11'h000, $past(i_irq_num), 1'b0}) else $error("irq vector");
  a_bad_irq: assert property (irq_go && i_irq_num > 4'hB |=> o_bad_vec && !o_bus_valid)
    else $error("bad irq not refused");
  a_vcall_addr: assert property (vc_go |=> o_bus_valid
    && o_bus_addr == 16'hFFC0 + {12'h000, $past(i_vcall_idx), 1'b0}) else $error("vcall");
  a_word_order: assert property (rq_go && i_size == MMVD_SZ_WORD |=> o_bus_valid ##1
    o_bus_valid && o_bus_addr == $past(o_bus_addr) + 16'h0001) else $error("word order");
  a_word_rdone: assert property (rq_go && !i_req.write && i_size == MMVD_SZ_WORD
    |-> ##3 o_rdone) else $error("word read done late");
  a_io_sel: assert property (o_bus_valid && o_bus_addr <= 16'h007F
    |-> o_sel.io && !o_sel.ext) else $error("io select wrong");
endmodule
bind mmvd_decoder mmvd_checker u_chk (.*);

/* File: verif/mmvd_mem_model.sv */
// byte memory standing in for ram, rom and the external area
// assumes reads are answered in the beat cycle, writes land at its closing edge
`timescale 1ns/1ps
module mmvd_mem_model (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_addr,
  input wire logic i_valid,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic flip = 1'b0;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i >> 8) ^ 8'(i);
    end
    mem[16'hFFFC] = 8'hFF;
  end
  // idle lines toggle so a stale byte can never pass for an answer
  assign o_rdata = i_valid ? mem[i_addr] : {8{flip}} ^ 8'hA5;
  always @(posedge i_clk_sys) begin
    flip <= ~flip;
    if (i_valid && i_write) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule

/* File: verif/memory_map_vector_decoder_test.sv */
// self-checking bench for the memory map and vector decoder
// assumes the memory model answers every beat
`timescale 1ns/1ps
module memory_map_vector_decoder_test;
  import mmvd_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  mmvd_beat_type i_req = '0;
  mmvd_size_type i_size = MMVD_SZ_BYTE;
  logic [15:0] i_wdata = '0, o_bus_addr, o_rdata, o_pc_reset, got;
  logic [7:0] i_rdata_byte, i_direct_off = '0, o_bus_wdata;
  logic i_direct_mode = 0, i_gpr_mode = 0, i_vector_call_instr = 0, i_irq_take = 0;
  logic i_reset_fetch = 0, i_mode_fetch = 0, bad_seen;
  logic [4:0] i_bank = '0;
  logic [2:0] i_gpr_idx = '0, i_vcall_idx = '0;
  logic [3:0] i_irq_num = '0;
  logic o_busy, o_bus_valid, o_bus_write, o_rdone, o_bad_vec;
  mmvd_sel_type o_sel;
  logic [15:0] ba[$];
  logic [7:0] bd[$];
  mmvd_sel_type bs[$];
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  mmvd_decoder dut (.*);
  mmvd_mem_model mem (.i_clk_sys(i_clk_sys), .i_addr(o_bus_addr), .i_valid(o_bus_valid),
    .i_write(o_bus_write), .i_wdata(o_bus_wdata), .o_rdata(i_rdata_byte));
  // ==========================================
  // beat recorder and hang guard
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (o_rdone) got <= o_rdata;
    if (o_bad_vec) bad_seen <= 1'b1;
    if (o_bus_valid) begin
      ba.push_back(o_bus_addr);
      bd.push_back(o_bus_wdata);
      bs.push_back(o_sel);
    end
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] fw(input logic [15:0] a);
    return {a[15:8] ^ a[7:0], 8'(a + 16'h0001) ^ 8'((a + 16'h0001) >> 8)};
  endfunction
  // k: 0 plain, 1 direct, 2 register bank, 3 vector call, 4 irq, 5 reset, 6 mode
  task automatic op(input int k, input logic [15:0] a, input logic w, input logic wsz,
                    input logic [15:0] wd, input logic [4:0] n);
    ba.delete();
    bd.delete();
    bs.delete();
    bad_seen = 1'b0;
    @(posedge i_clk_sys) #1;
    i_req = '{k < 3, w, a};
    i_size = wsz ? MMVD_SZ_WORD : MMVD_SZ_BYTE;
    i_wdata = wd;
    i_direct_off = a[7:0];
    i_gpr_idx = a[2:0];
    i_bank = n;
    i_vcall_idx = n[2:0];
    i_irq_num = n[3:0];
    {i_direct_mode, i_gpr_mode, i_vector_call_instr, i_irq_take, i_reset_fetch,
     i_mode_fetch} = k == 0 ? 6'h00 : 6'h20 >> (k - 1);
    @(posedge i_clk_sys) #1;
    i_req.valid = 1'b0;
    {i_direct_mode, i_gpr_mode, i_vector_call_instr, i_irq_take, i_reset_fetch,
     i_mode_fetch} = 6'h00;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
  // ==========================================
  // scenarios
  task automatic t_words();
    op(0, 16'h01FE, 1, 1, 16'hA55A, 0);
    chk("beat0", ba[0], 16'h01FE);
    chk("beat1", ba[1], 16'h01FF);
    chk("wdata", {bd[0], bd[1]}, 16'hA55A);
    chk("ram sel", 16'(bs[0].ram), 16'h0001);
    op(0, 16'h01FE, 0, 1, 0, 0);
    chk("word read", got, 16'hA55A);
  endtask
  task automatic t_modes();
    op(1, 16'h0090, 0, 0, 0, 0);
    chk("direct addr", ba[0], 16'h0090);
    chk("direct sel", 16'(bs[0].direct), 16'h0001);
    op(1, 16'h0020, 0, 0, 0, 0);
    chk("io sel", 16'(bs[0].io), 16'h0001);
    op(2, 16'h0005, 0, 0, 0, 5'h03);
    chk("bank addr", ba[0], 16'h011D);
    op(2, 16'h0007, 0, 0, 0, 5'h1F);
    chk("top bank", ba[0], 16'h01FF);
    chk("gpr sel", 16'(bs[0].gpr), 16'h0001);
    op(0, 16'h8000, 0, 0, 0, 0);
    chk("ext sel", 16'(bs[0].ext), 16'h0001);
    op(0, 16'hF000, 0, 0, 0, 0);
    chk("rom sel", 16'(bs[0].rom), 16'h0001);
  endtask
  task automatic t_vectors();
    for (int n = 0; n < 8; n++) begin
      op(3, 0, 0, 0, 0, 5'(n));
      chk("vcall", got, fw(16'hFFC0 + 16'(2 * n)));
      chk("vec sel", 16'(bs[0].vec), 16'h0001);
    end
    for (int n = 0; n < 13; n++) begin
      op(4, 0, 0, 0, 0, 5'(n));
      if (n < 12) chk("irq", got, fw(16'hFFFA - 16'(2 * n)));
      else chk("bad irq", {bad_seen, 15'(ba.size())}, 16'h8000);
    end
    op(5, 0, 0, 0, 0, 0);
    chk("reset vec", got, fw(16'hFFFE));
    op(6, 0, 0, 0, 0, 0);
    chk("mode addr", ba[0], 16'hFFFD);
    chk("mode byte", got, 16'(fw(16'hFFFD) >> 8));
    op(0, 16'hFFFC, 0, 0, 0, 0);
    chk("fill sel", 16'(bs[0].unused_fill), 16'h0001);
    chk("fill byte", got, 16'h00FF);
  endtask
  // reset in mid word write: the cut beat must not reach memory
  task automatic t_reset();
    @(posedge i_clk_sys) #1;
    i_req = '{1'b1, 1'b1, 16'h0150};
    i_size = MMVD_SZ_WORD;
    i_wdata = 16'h1234;
    @(posedge i_clk_sys) #1;
    i_req.valid = 1'b0;
    chk("busy", 16'(o_busy), 16'h0001);
    chk("write", 16'(o_bus_write), 16'h0001);
    i_resetn = 1'b0;
    #1;
    chk("reset busy", 16'(o_busy), 16'h0000);
    chk("reset valid", 16'(o_bus_valid), 16'h0000);
    chk("reset addr", o_bus_addr, 16'hFFFD);
    @(posedge i_clk_sys) #1;
    i_resetn = 1'b1;
    op(0, 16'h0150, 0, 0, 0, 0);
    chk("kept byte", got, 16'h0051);
  endtask
  initial begin
    repeat (3) @(posedge i_clk_sys);
    #1;
    i_resetn = 1'b1;
    chk("pc reset", o_pc_reset, 16'hFFFD);
    chk("idle addr", o_bus_addr, 16'hFFFD);
    t_words();
    t_modes();
    t_vectors();
    t_reset();
    tally_and_finish();
  end
endmodule
